// [design/cbc_flow_engine.sv]
// four dma channels feeding a block engine for cbc decryption
// assumes an external ram with one outstanding byte access and one-cycle ack
// What this block does
// R01: firmware holds the engine in reset by clearing the decrypt/enable bit.
// R02: firmware disables channels before changing their settings.
// R03: channel select picks which channel the per-channel writes reach.
// R04: code 0x05 moves ram bytes into the key input.
// R05: mode 0x01 wraps the channel back to base, resupplying the key.
// R06: firmware loads key base address high and low.
// R07: firmware writes key length to size low, zero to size high.
// R08: firmware clears offsets so every channel starts at base.
// R09: code 0x06 moves ciphertext bytes into the block input.
// R10: mode zero stops the channel after its byte count.
// R11: data, vector and output counts are multiples of sixteen.
// R12: code 0x07 moves vector and earlier ciphertext into xor input.
// R13: firmware places the vector right ahead of the ciphertext.
// R14: code 0x08 moves result bytes out to ram.
// R15: config bit 7 enables the channel transfer-complete interrupt.
// R16: firmware clears pending flags, then enables the channels.
// R17: flow config 0x02 xors the cipher output with the xor stream.
// R18: block config bits 1:0 select key size.
// R19: block config bit 2 zero selects decryption.
// R20: block config bit 3 starts the operation.
// R21: output channel completion interrupt marks end of decryption.
// R22: writing zero to the enable register stops every channel.
// R23: per block wait for data, key and xor, then emit sixteen bytes.
`default_nettype none
module cbc_flow_engine (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wr_strobe,
  input  wire logic [3:0]  wr_reg,
  input  wire logic [7:0]  wr_data,
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  output logic [3:0]       chan_enable,
  output logic [3:0]       chan_irq_flags,
  output logic             dma_irq,
  output logic             busy
);
  typedef struct packed {
    logic [1:0]             sel;
    logic [3:0]             en;
    logic [3:0]             flags;
    logic [3:0][7:0]        cfg;
    logic [3:0]             wrap;
    logic [3:0][15:0]       base;
    logic [3:0][15:0]       size;
    logic [3:0][15:0]       ofs;
    logic [7:0]             bcfg;
    logic [7:0]             dcfg;
    logic [31:0][7:0]       key;
    logic [15:0][7:0]       blk;
    logic [15:0][7:0]       xin;
    logic [5:0]             kcnt;
    logic [4:0]             bcnt;
    logic [4:0]             xcnt;
    logic [3:0]             oidx;
    cbc_flow_pkg::eng_state_t eng;
    cbc_flow_pkg::mem_state_t mst;
    logic [1:0]             mch;
    logic                   req;
    logic                   we;
    logic [15:0]            addr;
    logic [7:0]             wdata;
    logic                   irq;
    logic                   busy;
  } st_t;

  st_t        st_r;
  st_t        st_nxt;
  logic [3:0] elig;
  logic [5:0] klen;
  logic       start_ok;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [7:0] buf_out_data;
  logic       buf_pop;
  logic       emit;
  logic [7:0] result_byte;

  ////////////////////////////////////////////////////////////////////////////
  // key length from the size field; the reserved code reads as 256-bit
  // R18: key size select
  always_comb begin
    unique case (st_r.bcfg[1:0])
      cbc_flow_pkg::KEY_SIZE_128: klen = cbc_flow_pkg::KEY_BYTES_128;
      cbc_flow_pkg::KEY_SIZE_192: klen = cbc_flow_pkg::KEY_BYTES_192;
      default:                    klen = cbc_flow_pkg::KEY_BYTES_256;
    endcase
  end

  // R19: bit 2 clear means decrypt; R20: bit 3 starts
  assign start_ok = st_r.bcfg[cbc_flow_pkg::BCFG_START]
                    && !st_r.bcfg[cbc_flow_pkg::BCFG_DECRYPT_N];

  ////////////////////////////////////////////////////////////////////////////
  // per-channel readiness; key and input fills stall while a block emits
  // so the engine never sees its operands change under it
  genvar c;
  generate
    for (c = 0; c < cbc_flow_pkg::NUM_CHAN; c++) begin : g_elig
      logic [6:0] code;
      assign code = st_r.cfg[c][6:0];
      // R04 R09 R12 R14: route by config code; operand fetches wait for
      // start, as the stores are held clear until then and would drop bytes
      assign elig[c] = st_r.en[c] && (
        ((code == cbc_flow_pkg::CODE_KEY_IN) && (st_r.kcnt < klen)
          && start_ok && (st_r.eng == cbc_flow_pkg::ENG_IDLE)) ||
        ((code == cbc_flow_pkg::CODE_BLOCK_IN)
          && (st_r.bcnt < cbc_flow_pkg::BLOCK_BYTES)
          && start_ok && (st_r.eng == cbc_flow_pkg::ENG_IDLE)) ||
        ((code == cbc_flow_pkg::CODE_XOR_IN)
          && (st_r.xcnt < cbc_flow_pkg::BLOCK_BYTES)
          && start_ok && (st_r.eng == cbc_flow_pkg::ENG_IDLE)) ||
        ((code == cbc_flow_pkg::CODE_RESULT) && buf_out_valid));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // stand-in block transform keyed by the loaded key, then the cbc xor
  // R17: optional xor with vector stream
  always_comb begin
    result_byte = st_r.blk[st_r.oidx] ^ st_r.key[{1'b0, st_r.oidx}];
    if (st_r.dcfg == cbc_flow_pkg::FLOW_XOR_OUT) begin
      result_byte = result_byte ^ st_r.xin[st_r.oidx];
    end
  end

  // R23: emit bytes in order, stalled by the buffer
  assign emit    = (st_r.eng == cbc_flow_pkg::ENG_EMIT) && buf_in_ready;
  // output channel pops exactly when it issues its write
  assign buf_pop = (st_r.mst == cbc_flow_pkg::MEM_IDLE) && (elig != 4'h0)
                   && (st_r.cfg[st_r.mch][6:0] == cbc_flow_pkg::CODE_RESULT)
                   && elig[st_r.mch];

  two_slot_buffer u_out_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (st_r.eng == cbc_flow_pkg::ENG_EMIT),
    .in_ready  (buf_in_ready),
    .in_data   (result_byte),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: firmware writes first, hardware events after so they win
  always_comb begin
    logic [1:0]  ch;
    logic [6:0]  code;
    logic [15:0] nofs;
    ch     = st_r.mch;
    code   = st_r.cfg[st_r.mch][6:0];
    nofs   = st_r.ofs[st_r.mch] + 16'h0001;
    st_nxt = st_r;
    st_nxt.req = 1'b0;

    if (wr_strobe) begin
      // R03: per-channel writes follow the select register
      unique case (wr_reg)
        cbc_flow_pkg::REG_CHAN_SELECT:   st_nxt.sel = wr_data[1:0];
        cbc_flow_pkg::REG_CHAN_CONFIG:   st_nxt.cfg[st_r.sel] = wr_data;
        cbc_flow_pkg::REG_CHAN_MODE:
          st_nxt.wrap[st_r.sel] = wr_data[0];
        cbc_flow_pkg::REG_BASE_HIGH:
          st_nxt.base[st_r.sel][15:8] = wr_data;
        cbc_flow_pkg::REG_BASE_LOW:
          st_nxt.base[st_r.sel][7:0] = wr_data;
        cbc_flow_pkg::REG_SIZE_HIGH:
          st_nxt.size[st_r.sel][15:8] = wr_data;
        cbc_flow_pkg::REG_SIZE_LOW:
          st_nxt.size[st_r.sel][7:0] = wr_data;
        cbc_flow_pkg::REG_OFFSET_HIGH:
          st_nxt.ofs[st_r.sel][15:8] = wr_data;
        cbc_flow_pkg::REG_OFFSET_LOW:
          st_nxt.ofs[st_r.sel][7:0] = wr_data;
        // R22: zero stops all channels
        cbc_flow_pkg::REG_CHAN_ENABLE:   st_nxt.en = wr_data[3:0];
        cbc_flow_pkg::REG_CHAN_IRQ_FLAG: st_nxt.flags = wr_data[3:0];
        cbc_flow_pkg::REG_BLOCK_CONFIG:  st_nxt.bcfg = wr_data;
        cbc_flow_pkg::REG_FLOW_CONFIG:   st_nxt.dcfg = wr_data;
        default:                         st_nxt.sel = st_r.sel;
      endcase
    end

    // memory side: keep the current channel while ready, else pick the lowest ready one, one byte at a time
    unique case (st_r.mst)
      cbc_flow_pkg::MEM_IDLE: begin
        // channel is held while its access is in flight, so the ack
        // lands on the channel that issued it
        if (elig[st_r.mch]) begin
          st_nxt.req   = 1'b1;
          st_nxt.we    = (code == cbc_flow_pkg::CODE_RESULT);
          st_nxt.addr  = st_r.base[ch] + st_r.ofs[ch];
          st_nxt.wdata = buf_out_data;
          st_nxt.mst   = cbc_flow_pkg::MEM_WAIT;
        end else begin
          for (int i = cbc_flow_pkg::NUM_CHAN - 1; i >= 0; i--) begin
            if (elig[i]) begin
              st_nxt.mch = 2'(i);
            end
          end
        end
      end
      cbc_flow_pkg::MEM_WAIT: begin
        if (mem_ack) begin
          st_nxt.mst = cbc_flow_pkg::MEM_IDLE;
          // R04: key byte lands in the key store
          if (code == cbc_flow_pkg::CODE_KEY_IN) begin
            st_nxt.key[st_r.kcnt[4:0]] = mem_rdata;
            st_nxt.kcnt = st_r.kcnt + 6'h01;
          end
          // R09: ciphertext byte into block input
          if (code == cbc_flow_pkg::CODE_BLOCK_IN) begin
            st_nxt.blk[st_r.bcnt[3:0]] = mem_rdata;
            st_nxt.bcnt = st_r.bcnt + 5'h01;
          end
          // R12: vector or prior ciphertext into xor input
          if (code == cbc_flow_pkg::CODE_XOR_IN) begin
            st_nxt.xin[st_r.xcnt[3:0]] = mem_rdata;
            st_nxt.xcnt = st_r.xcnt + 5'h01;
          end
          if (nofs >= st_r.size[ch]) begin
            // R05: wrap back to base
            if (st_r.wrap[ch] == cbc_flow_pkg::MODE_WRAP) begin
              st_nxt.ofs[ch] = cbc_flow_pkg::RESET_WORD;
            end else begin
              // R10: stop after the byte count; R21: completion flag
              st_nxt.ofs[ch]  = nofs;
              st_nxt.en[ch]   = 1'b0;
              st_nxt.flags[ch] = 1'b1;
            end
          end else begin
            st_nxt.ofs[ch] = nofs;
          end
        end else begin
          st_nxt.req = 1'b0;
        end
      end
      default: st_nxt.mst = cbc_flow_pkg::MEM_IDLE;
    endcase

    // engine: start when all operands are in, emit sixteen bytes
    unique case (st_r.eng)
      cbc_flow_pkg::ENG_IDLE: begin
        // R23: wait for full block, xor bytes and key
        if (start_ok && (st_r.kcnt >= klen)
            && (st_r.bcnt == cbc_flow_pkg::BLOCK_BYTES)
            && (st_r.xcnt == cbc_flow_pkg::BLOCK_BYTES)) begin
          st_nxt.eng  = cbc_flow_pkg::ENG_EMIT;
          st_nxt.oidx = 4'h0;
        end
      end
      cbc_flow_pkg::ENG_EMIT: begin
        if (emit) begin
          st_nxt.oidx = st_r.oidx + 4'h1;
          if (st_r.oidx == 4'hf) begin
            // block consumed; key is refetched through the wrap channel
            st_nxt.eng  = cbc_flow_pkg::ENG_IDLE;
            st_nxt.bcnt = 5'h00;
            st_nxt.xcnt = 5'h00;
            st_nxt.kcnt = 6'h00;
          end
        end
      end
      default: st_nxt.eng = cbc_flow_pkg::ENG_IDLE;
    endcase

    // R01: clearing start holds the engine and its operand stores in reset
    if (!st_nxt.bcfg[cbc_flow_pkg::BCFG_START]
        || st_nxt.bcfg[cbc_flow_pkg::BCFG_DECRYPT_N]) begin
      st_nxt.eng  = cbc_flow_pkg::ENG_IDLE;
      st_nxt.bcnt = 5'h00;
      st_nxt.xcnt = 5'h00;
      st_nxt.kcnt = 6'h00;
    end

    // R15: interrupt only where the channel enables it
    st_nxt.irq = 1'b0;
    for (int i = 0; i < cbc_flow_pkg::NUM_CHAN; i++) begin
      if (st_nxt.flags[i] && st_nxt.cfg[i][cbc_flow_pkg::CFG_IRQ_EN]) begin
        st_nxt.irq = 1'b1;
      end
    end
    st_nxt.busy = (st_nxt.en != 4'h0)
                  || (st_nxt.eng != cbc_flow_pkg::ENG_IDLE)
                  || (st_nxt.mst != cbc_flow_pkg::MEM_IDLE);
  end

  // note: buffer pop happens at issue, so a refused write cannot lose data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign mem_req        = st_r.req;
  assign mem_we         = st_r.we;
  assign mem_addr       = st_r.addr;
  assign mem_wdata      = st_r.wdata;
  assign chan_enable    = st_r.en;
  assign chan_irq_flags = st_r.flags;
  assign dma_irq        = st_r.irq;
  assign busy           = st_r.busy;
endmodule
`default_nettype wire

// [design/cbc_flow_pkg.sv]
// package for the cbc decryption data-flow engine and its four dma channels
// assumes one system clock, firmware writes arriving as single-cycle strobes
`default_nettype none
package cbc_flow_pkg;
  // firmware write port register identifiers
  localparam logic [3:0] REG_CHAN_SELECT   = 4'h0;
  localparam logic [3:0] REG_CHAN_CONFIG   = 4'h1;
  localparam logic [3:0] REG_CHAN_MODE     = 4'h2;
  localparam logic [3:0] REG_BASE_HIGH     = 4'h3;
  localparam logic [3:0] REG_BASE_LOW      = 4'h4;
  localparam logic [3:0] REG_SIZE_HIGH     = 4'h5;
  localparam logic [3:0] REG_SIZE_LOW      = 4'h6;
  localparam logic [3:0] REG_OFFSET_HIGH   = 4'h7;
  localparam logic [3:0] REG_OFFSET_LOW    = 4'h8;
  localparam logic [3:0] REG_CHAN_ENABLE   = 4'h9;
  localparam logic [3:0] REG_CHAN_IRQ_FLAG = 4'ha;
  localparam logic [3:0] REG_BLOCK_CONFIG  = 4'hb;
  localparam logic [3:0] REG_FLOW_CONFIG   = 4'hc;
  // channel configuration codes and fields
  localparam logic [6:0] CODE_KEY_IN   = 7'h05;
  localparam logic [6:0] CODE_BLOCK_IN = 7'h06;
  localparam logic [6:0] CODE_XOR_IN   = 7'h07;
  localparam logic [6:0] CODE_RESULT   = 7'h08;
  localparam int         CFG_IRQ_EN    = 7;
  localparam logic       MODE_WRAP     = 1'b1;
  // block configuration fields
  localparam int         BCFG_DECRYPT_N = 2;
  localparam int         BCFG_START     = 3;
  localparam logic [1:0] KEY_SIZE_128   = 2'h0;
  localparam logic [1:0] KEY_SIZE_192   = 2'h1;
  localparam logic [5:0] KEY_BYTES_128  = 6'h10;
  localparam logic [5:0] KEY_BYTES_192  = 6'h18;
  localparam logic [5:0] KEY_BYTES_256  = 6'h20;
  localparam logic [7:0] FLOW_XOR_OUT   = 8'h02;
  localparam logic [4:0] BLOCK_BYTES    = 5'h10;
  localparam int         NUM_CHAN       = 4;
  // reset values
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_EMIT = 1'b1
  } eng_state_t;
  typedef enum logic [0:0] {
    MEM_IDLE = 1'b0,
    MEM_WAIT = 1'b1
  } mem_state_t;
endpackage
`default_nettype wire

// [design/two_slot_buffer.sv]
// two-entry byte buffer with valid/ready on both sides
// assumes the consumer may stall; in_ready drops only when both slots hold
`default_nettype none
module two_slot_buffer (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  typedef struct packed {
    logic [1:0][7:0] slot;
    logic [1:0]      cnt;
    logic            rd;
    logic            wr;
  } buf_t;

  buf_t st_r;
  buf_t st_nxt;

  assign in_ready  = (st_r.cnt != 2'h2);
  assign out_valid = (st_r.cnt != 2'h0);
  assign out_data  = st_r.slot[st_r.rd];

  ////////////////////////////////////////////////////////////////////////////
  // push and pop may happen together; count only moves on one-sided ops
  always_comb begin
    logic push;
    logic pop;
    push   = 1'b0;
    pop    = 1'b0;
    st_nxt = st_r;
    push   = in_valid && in_ready;
    pop    = out_ready && out_valid;
    if (push) begin
      st_nxt.slot[st_r.wr] = in_data;
      st_nxt.wr            = ~st_r.wr;
    end
    if (pop) begin
      st_nxt.rd = ~st_r.rd;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 2'h1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// [tb/cbc_flow_monitor.sv]
// port checker for the cbc flow engine
// assumes binding to cbc_flow_engine, one clock, sync reset
`default_nettype none
module cbc_flow_monitor (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        wr_strobe,
  input wire logic [3:0]  wr_reg,
  input wire logic [7:0]  wr_data,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_ack,
  input wire logic [7:0]  mem_rdata,
  input wire logic [3:0]  chan_enable,
  input wire logic [3:0]  chan_irq_flags,
  input wire logic        dma_irq,
  input wire logic        busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pend_r;
  logic pend_nxt;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  // access in flight: set by request, cleared by ack
  always_comb begin
    pend_nxt = pend_r;
    if (mem_req) pend_nxt = 1'b1;
    else if (mem_ack) pend_nxt = 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) pend_r <= 1'b0;
    else pend_r <= pend_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // steps of longer behaviours
  sequence s_off3;
    (chan_enable == 4'h0) [*3];
  endsequence
  sequence s_flag_clr;
    wr_strobe && wr_reg == cbc_flow_pkg::REG_CHAN_IRQ_FLAG &&
      wr_data == 8'h00;
  endsequence

  reset_zero_a:
    assert property (disable iff (1'b0) rst |=> !mem_req && !busy &&
      chan_enable == 4'h0 && chan_irq_flags == 4'h0 && !dma_irq)
    else $error("outputs not cleared by reset");
  one_outstanding_a:
    assert property (pend_r |-> !mem_req)
    else $error("second access while one is pending");
  addr_hold_a:
    assert property (pend_r |-> $stable(mem_addr) && $stable(mem_we))
    else $error("access address moved while pending");
  enable_write_a:
    assert property (wr_strobe && wr_reg == cbc_flow_pkg::REG_CHAN_ENABLE
      |=> (chan_enable & ~$past(wr_data[3:0])) == 4'h0)
    else $error("channel enable not taken from write");
  idle_no_req_a:
    assert property (s_off3 |-> !mem_req)
    else $error("access with all channels off");
  irq_cause_a:
    assert property ($rose(dma_irq) |-> chan_irq_flags != 4'h0)
    else $error("interrupt without a pending flag");
  flag_clear_a:
    assert property (s_flag_clr ##0 (!mem_ack && !$past(mem_ack))
      |=> chan_irq_flags == 4'h0)
    else $error("flags not cleared by write");
  done_disables_a:
    assert property (!$past(wr_strobe) |->
      (chan_irq_flags & ~$past(chan_irq_flags) & chan_enable) == 4'h0)
    else $error("channel still enabled after completing");
  busy_enable_a:
    assert property ((chan_enable != 4'h0) && ($past(chan_enable) != 4'h0)
      |-> busy)
    else $error("busy low with channels enabled");
endmodule

bind cbc_flow_engine cbc_flow_monitor mon_u (
  .clk_sys(clk_sys), .rst(rst), .wr_strobe(wr_strobe), .wr_reg(wr_reg),
  .wr_data(wr_data), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .chan_enable(chan_enable),
  .chan_irq_flags(chan_irq_flags), .dma_irq(dma_irq), .busy(busy)
);
`default_nettype wire

// [tb/tb_cbc_flow_engine.sv]
// self-checking bench for the cbc flow engine
// assumes the bench plays firmware and the external ram itself
`default_nettype none
module tb_cbc_flow_engine;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, rst, wr_strobe, mem_ack, mem_req, mem_we;
  logic        dma_irq, busy;
  logic [3:0]  wr_reg, chan_enable, chan_irq_flags;
  logic [7:0]  wr_data, mem_wdata, mem_rdata;
  logic [15:0] mem_addr;
  logic [7:0]  ram [0:65535];
  int          fail_count, n_tests, rd_cnt, wr_cnt;

  cbc_flow_engine dut_u (
    .clk_sys(clk_sys), .rst(rst), .wr_strobe(wr_strobe), .wr_reg(wr_reg),
    .wr_data(wr_data), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .chan_enable(chan_enable),
    .chan_irq_flags(chan_irq_flags), .dma_irq(dma_irq), .busy(busy)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  // ram: alternates prompt and slow answers; released data is inverted
  initial begin : ram_side
    logic [15:0] a;
    logic        w;
    int          lat;
    lat = 0;
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    forever begin
      @(posedge clk_sys);
      if (mem_req === 1'b1) begin
        a = mem_addr;
        w = mem_we;
        if (w) ram[a] = mem_wdata;
        repeat (lat) @(posedge clk_sys);
        #1;
        mem_ack = 1'b1;
        if (w) wr_cnt++;
        else mem_rdata = ram[a];
        if (!w && a[15:8] == 8'h02) rd_cnt++;
        @(posedge clk_sys);
        #1;
        mem_ack = 1'b0;
        mem_rdata = ~mem_rdata;
        lat = 2 - lat;
      end
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  // strobe held one cycle, then a gap so calls never collide
  task automatic wr(input logic [3:0] r, input logic [7:0] d);
    wr_reg = r;
    wr_data = d;
    wr_strobe = 1'b1;
    @(posedge clk_sys);
    #1;
    wr_strobe = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic cfg(input logic [7:0] ch, input logic [7:0] code,
                     input logic [7:0] md, input logic [15:0] base,
                     input logic [15:0] size);
    wr(cbc_flow_pkg::REG_CHAN_SELECT, ch);
    wr(cbc_flow_pkg::REG_CHAN_CONFIG, code);
    wr(cbc_flow_pkg::REG_CHAN_MODE, md);
    wr(cbc_flow_pkg::REG_BASE_HIGH, base[15:8]);
    wr(cbc_flow_pkg::REG_BASE_LOW, base[7:0]);
    wr(cbc_flow_pkg::REG_SIZE_HIGH, size[15:8]);
    wr(cbc_flow_pkg::REG_SIZE_LOW, size[7:0]);
    wr(cbc_flow_pkg::REG_OFFSET_HIGH, 8'h00);
    wr(cbc_flow_pkg::REG_OFFSET_LOW, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one full decryption pass; vector sits right ahead of the data
  task automatic run(input logic [7:0] flow, input logic [1:0] ksz,
                     input logic [5:0] klen, input int nblk);
    logic [7:0] e;
    int         n;
    n = 16 * nblk;
    for (int i = 0; i < 768; i++)
      ram[16'h0100 + i] = (i < 512) ? 8'(i * 37 + nblk) : 8'h5a;
    rd_cnt = 0;
    wr_cnt = 0;
    wr(cbc_flow_pkg::REG_BLOCK_CONFIG, 8'h00);
    wr(cbc_flow_pkg::REG_CHAN_ENABLE, 8'h00);
    cfg(8'h00, 8'h05, 8'h01, 16'h0100, {10'h0, klen});
    cfg(8'h01, 8'h06, 8'h00, 16'h0210, 16'(n));
    cfg(8'h02, 8'h07, 8'h00, 16'h0200, 16'(n));
    cfg(8'h03, 8'h88, 8'h00, 16'h0300, 16'(n));
    wr(cbc_flow_pkg::REG_CHAN_IRQ_FLAG, 8'h00);
    wr(cbc_flow_pkg::REG_CHAN_ENABLE, 8'h0f);
    chk_val("enable", 16'h000f, {12'h0, chan_enable});
    wr(cbc_flow_pkg::REG_FLOW_CONFIG, flow);
    wr(cbc_flow_pkg::REG_BLOCK_CONFIG, {5'h01, 1'b0, ksz});
    for (int k = 0; k < 4000 && dma_irq !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk_bit("dma_irq", 1'b1, dma_irq);
    chk_val("flags", 16'h000e, {12'h0, chan_irq_flags});
    chk_val("enable_done", 16'h0001, {12'h0, chan_enable});
    for (int i = 0; i < n; i++) begin
      e = ram[16'h0210 + i] ^ ram[16'h0100 + i % 16];
      if (flow == cbc_flow_pkg::FLOW_XOR_OUT) e = e ^ ram[16'h0200 + i];
      chk_val("plain_byte", {8'h0, e}, {8'h0, ram[16'h0300 + i]});
    end
    chk_val("past_end", 16'h005a, {8'h0, ram[16'h0300 + n]});
    chk_val("writes", 16'(n), 16'(wr_cnt));
    chk_val("reads", 16'(2 * n), 16'(rd_cnt));
    wr(cbc_flow_pkg::REG_BLOCK_CONFIG, 8'h04);
    wr(cbc_flow_pkg::REG_CHAN_ENABLE, 8'h00);
    chk_val("enable_off", 16'h0000, {12'h0, chan_enable});
    for (int k = 0; k < 50 && busy !== 1'b0; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk_bit("busy", 1'b0, busy);
    wr(cbc_flow_pkg::REG_CHAN_IRQ_FLAG, 8'h00);
    chk_val("flags_clear", 16'h0000, {12'h0, chan_irq_flags});
    chk_bit("irq_clear", 1'b0, dma_irq);
  endtask

  // watchdog: all passes need a few thousand cycles at most
  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    wr_strobe = 1'b0;
    wr_reg = 4'h0;
    wr_data = 8'h00;
    fail_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk_val("reset_enable", 16'h0000, {12'h0, chan_enable});
    run(cbc_flow_pkg::FLOW_XOR_OUT, cbc_flow_pkg::KEY_SIZE_128,
        cbc_flow_pkg::KEY_BYTES_128, 2);
    run(8'h00, cbc_flow_pkg::KEY_SIZE_128,
        cbc_flow_pkg::KEY_BYTES_128, 1);
    run(cbc_flow_pkg::FLOW_XOR_OUT, cbc_flow_pkg::KEY_SIZE_192,
        cbc_flow_pkg::KEY_BYTES_192, 1);
    run(cbc_flow_pkg::FLOW_XOR_OUT, 2'h2,
        cbc_flow_pkg::KEY_BYTES_256, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
